// [inc/mac_queue_pkg.sv]
// Package: register map, fields and constants for the queue and threshold block
package mac_queue_pkg;

  // ----------------------------------------
  // Register byte addresses (index x 4, since 0xC6 is not word aligned)
  // ----------------------------------------
  localparam logic [31:0] IDX_TX_DESCRIPTOR_ENQUEUE = 32'h800100BC;
  localparam logic [31:0] IDX_TX_STATUS_QUEUE_BASE_ADDRESS = 32'h800100C0;
  localparam logic [31:0] IDX_TX_STATUS_QUEUE_BASE_LENGTH = 32'h800100C4;
  localparam logic [31:0] IDX_TX_STATUS_QUEUE_CURRENT_LENGTH = 32'h800100C6;
  localparam logic [31:0] IDX_TX_STATUS_QUEUE_CURRENT_ADDRESS = 32'h800100C8;
  localparam logic [31:0] IDX_RX_DATA_FIFO_THRESHOLD = 32'h800100D0;
  localparam logic [31:0] IDX_TX_DATA_FIFO_THRESHOLD = 32'h800100D4;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_TX_DESCRIPTOR_ENQUEUE = IDX_TX_DESCRIPTOR_ENQUEUE[9:0] * 12'h004;
  localparam logic [11:0] ADDR_TX_STATUS_QUEUE_BASE_ADDRESS =
    IDX_TX_STATUS_QUEUE_BASE_ADDRESS[9:0] * 12'h004;
  localparam logic [11:0] ADDR_TX_STATUS_QUEUE_BASE_LENGTH =
    IDX_TX_STATUS_QUEUE_BASE_LENGTH[9:0] * 12'h004;
  localparam logic [11:0] ADDR_TX_STATUS_QUEUE_CURRENT_LENGTH =
    IDX_TX_STATUS_QUEUE_CURRENT_LENGTH[9:0] * 12'h004;
  localparam logic [11:0] ADDR_TX_STATUS_QUEUE_CURRENT_ADDRESS =
    IDX_TX_STATUS_QUEUE_CURRENT_ADDRESS[9:0] * 12'h004;
  localparam logic [11:0] ADDR_RX_DATA_FIFO_THRESHOLD = IDX_RX_DATA_FIFO_THRESHOLD[9:0] * 12'h004;
  localparam logic [11:0] ADDR_TX_DATA_FIFO_THRESHOLD = IDX_TX_DATA_FIFO_THRESHOLD[9:0] * 12'h004;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int INCREMENT_LSB = 0;
  localparam int INCREMENT_W = 8;
  localparam int VALUE_LSB = 16;
  localparam int VALUE_W = 16;
  localparam int LENGTH_W = 16;
  localparam int SOFT_LSB = 0;
  localparam int HARD_LSB = 16;
  localparam int LEVEL_W = 14;
  localparam logic [15:0] LEVEL_MASK = 16'h3FFC;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  localparam int IDLE_CLOCKS = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/fifo_request_scheduler.sv]
// Module: soft and hard threshold bus request scheduler for one data FIFO
`timescale 1ns/1ps
module fifo_request_scheduler #(
  parameter int LEVEL_W = 14
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [LEVEL_W-1:0] fill_words,
  input  wire logic [LEVEL_W-1:0] soft_level,
  input  wire logic [LEVEL_W-1:0] hard_level,
  input  wire logic               bus_idle,
  input  wire logic               resource_ok,
  input  wire logic               extra_event,
  output logic                    bus_request
);

  logic next_bus_request;
  logic over_soft;
  logic over_hard;

  always_comb begin
    over_soft = fill_words > soft_level;
    over_hard = fill_words > hard_level;
    next_bus_request = 1'b0;
    if (resource_ok) begin
      if (over_hard || extra_event) begin
        next_bus_request = 1'b1;
      end else if (over_soft && bus_idle) begin
        next_bus_request = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_request <= 1'b0;
    end else begin
      bus_request <= next_bus_request;
    end
  end

endmodule

// [rtl/mac_queue_and_fifo_thresholds.sv]
// Module: transmit descriptor count, status queue pointers and FIFO threshold requests
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module mac_queue_and_fifo_thresholds #(
  parameter int FIFO_LEVEL_W = 14
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // MAC side
  input  wire logic                    descriptors_read,
  input  wire logic [7:0]              descriptors_read_count,
  input  wire logic                    status_written,
  input  wire logic [7:0]              status_bytes_written,
  input  wire logic                    ahb_transfer,
  input  wire logic [FIFO_LEVEL_W-1:0] rx_fifo_words,
  input  wire logic                    rx_descriptor_active,
  input  wire logic                    rx_end_of_frame,
  input  wire logic [FIFO_LEVEL_W-1:0] tx_fifo_empty_words,
  input  wire logic                    tx_descriptor_active,
  output logic                         tx_descriptor_request,
  output logic                         rx_data_request,
  output logic                         tx_data_request,
  output logic [31:0]                  status_write_address
);

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  wr_state_t   wr_state, next_wr_state;
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;

  logic [15:0] valid_descriptor_count, next_valid_descriptor_count;
  logic [31:0] status_queue_base_field, next_status_queue_base_field;
  logic [15:0] status_queue_length_field, next_status_queue_length_field;
  logic [15:0] status_queue_remaining_bytes, next_status_queue_remaining_bytes;
  logic [31:0] status_write_pointer, next_status_write_pointer;
  logic [15:0] rx_thr_soft, next_rx_thr_soft;
  logic [15:0] rx_thr_hard, next_rx_thr_hard;
  logic [15:0] tx_thr_soft, next_tx_thr_soft;
  logic [15:0] tx_thr_hard, next_tx_thr_hard;
  logic [2:0]  idle_count, next_idle_count;
  logic        tx_descriptor_request_q, next_tx_descriptor_request;
  logic        awready_q, next_awready;
  logic        wready_q, next_wready;
  logic        bvalid_q, next_bvalid;
  logic        arready_q, next_arready;
  logic        do_write;
  logic [15:0] wr_val16;
  logic [15:0] wr_hi16;

  // ----------------------------------------
  // AXI write channel and register writes
  // ----------------------------------------
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = bresp;
    do_write = 1'b0;
    case (wr_state)
      WR_IDLE: begin
        if (s_axi_awvalid && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_strb = s_axi_wstrb;
        end
        if (next_aw_held && next_w_held) begin
          do_write = 1'b1;
          next_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_state = WR_IDLE;
        end
      end
      default: next_wr_state = WR_IDLE;
    endcase
    wr_val16 = next_w_data[15:0];
    wr_hi16 = next_w_data[31:16];

    next_valid_descriptor_count = valid_descriptor_count;
    next_status_queue_base_field = status_queue_base_field;
    next_status_queue_length_field = status_queue_length_field;
    next_status_queue_remaining_bytes = status_queue_remaining_bytes;
    next_status_write_pointer = status_write_pointer;
    next_rx_thr_soft = rx_thr_soft;
    next_rx_thr_hard = rx_thr_hard;
    next_tx_thr_soft = tx_thr_soft;
    next_tx_thr_hard = tx_thr_hard;

    // Hardware events first; a simultaneous software write is applied on top
    if (descriptors_read) begin
      next_valid_descriptor_count = valid_descriptor_count - {8'h00, descriptors_read_count};
    end
    if (status_written) begin
      if (status_queue_remaining_bytes <= {8'h00, status_bytes_written}) begin
        next_status_write_pointer = status_queue_base_field;
        next_status_queue_remaining_bytes = status_queue_length_field;
      end else begin
        next_status_write_pointer = status_write_pointer + {24'h000000, status_bytes_written};
        next_status_queue_remaining_bytes =
          status_queue_remaining_bytes - {8'h00, status_bytes_written};
      end
    end

    if (do_write) begin
      next_bresp = mac_queue_pkg::RESP_OKAY;
      if (next_aw_addr == mac_queue_pkg::ADDR_TX_DESCRIPTOR_ENQUEUE) begin
        if (next_w_strb[0]) begin
          // Increment adds, value half ignores writes
          next_valid_descriptor_count = next_valid_descriptor_count
            + {8'h00, next_w_data[mac_queue_pkg::INCREMENT_LSB +: mac_queue_pkg::INCREMENT_W]};
        end
      end else if (next_aw_addr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_ADDRESS) begin
        next_status_queue_base_field = next_w_data;
      end else if (next_aw_addr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_LENGTH) begin
        next_status_queue_length_field = wr_val16;
      end else if (next_aw_addr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_LENGTH) begin
        next_status_queue_remaining_bytes = wr_val16;
      end else if (next_aw_addr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_ADDRESS) begin
        next_status_write_pointer = next_w_data;
      end else if (next_aw_addr == mac_queue_pkg::ADDR_RX_DATA_FIFO_THRESHOLD) begin
        next_rx_thr_soft = wr_val16 & mac_queue_pkg::LEVEL_MASK;
        next_rx_thr_hard = wr_hi16 & mac_queue_pkg::LEVEL_MASK;
      end else if (next_aw_addr == mac_queue_pkg::ADDR_TX_DATA_FIFO_THRESHOLD) begin
        next_tx_thr_soft = wr_val16 & mac_queue_pkg::LEVEL_MASK;
        next_tx_thr_hard = wr_hi16 & mac_queue_pkg::LEVEL_MASK;
      end else begin
        next_bresp = mac_queue_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (!rvalid && s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp = mac_queue_pkg::RESP_OKAY;
      if (s_axi_araddr == mac_queue_pkg::ADDR_TX_DESCRIPTOR_ENQUEUE) begin
        next_rdata = {valid_descriptor_count, 16'h0000};
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_ADDRESS) begin
        next_rdata = status_queue_base_field;
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_LENGTH) begin
        next_rdata = {16'h0000, status_queue_length_field};
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_LENGTH) begin
        next_rdata = {16'h0000, status_queue_remaining_bytes};
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_ADDRESS) begin
        next_rdata = status_write_pointer;
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_RX_DATA_FIFO_THRESHOLD) begin
        next_rdata = {rx_thr_hard, rx_thr_soft};
      end else if (s_axi_araddr == mac_queue_pkg::ADDR_TX_DATA_FIFO_THRESHOLD) begin
        next_rdata = {tx_thr_hard, tx_thr_soft};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = mac_queue_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // Bus idle detection and descriptor request
  // ----------------------------------------
  always_comb begin
    next_idle_count = idle_count;
    if (ahb_transfer) begin
      next_idle_count = 3'h0;
    end else if (idle_count < 3'(mac_queue_pkg::IDLE_CLOCKS)) begin
      next_idle_count = idle_count + 3'h1;
    end
    next_tx_descriptor_request = (valid_descriptor_count != 16'h0000);
    // Decoded from next state so the registered copies match the held flags
    next_awready = (next_wr_state == WR_IDLE) && !next_aw_held;
    next_wready = (next_wr_state == WR_IDLE) && !next_w_held;
    next_bvalid = (next_wr_state == WR_RESP);
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= mac_queue_pkg::RESET_VALUE;
      w_strb <= 4'h0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= mac_queue_pkg::RESET_VALUE;
      rresp <= 2'h0;
      valid_descriptor_count <= 16'h0000;
      status_queue_base_field <= mac_queue_pkg::RESET_VALUE;
      status_queue_length_field <= 16'h0000;
      status_queue_remaining_bytes <= 16'h0000;
      status_write_pointer <= mac_queue_pkg::RESET_VALUE;
      rx_thr_soft <= 16'h0000;
      rx_thr_hard <= 16'h0000;
      tx_thr_soft <= 16'h0000;
      tx_thr_hard <= 16'h0000;
      idle_count <= 3'h0;
      tx_descriptor_request_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      valid_descriptor_count <= next_valid_descriptor_count;
      status_queue_base_field <= next_status_queue_base_field;
      status_queue_length_field <= next_status_queue_length_field;
      status_queue_remaining_bytes <= next_status_queue_remaining_bytes;
      status_write_pointer <= next_status_write_pointer;
      rx_thr_soft <= next_rx_thr_soft;
      rx_thr_hard <= next_rx_thr_hard;
      tx_thr_soft <= next_tx_thr_soft;
      tx_thr_hard <= next_tx_thr_hard;
      idle_count <= next_idle_count;
      tx_descriptor_request_q <= next_tx_descriptor_request;
      awready_q <= next_awready;
      wready_q <= next_wready;
      bvalid_q <= next_bvalid;
      arready_q <= next_arready;
    end
  end

  // Handshake outputs come straight from flops: each ready only while its own channel holds nothing
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign tx_descriptor_request = tx_descriptor_request_q;
  assign status_write_address = status_write_pointer;

  // ----------------------------------------
  // Data FIFO schedulers
  // ----------------------------------------
  fifo_request_scheduler #(
    .LEVEL_W (FIFO_LEVEL_W)
  ) u_rx_sched (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .fill_words  (rx_fifo_words),
    .soft_level  (rx_thr_soft[FIFO_LEVEL_W-1:0]),
    .hard_level  (rx_thr_hard[FIFO_LEVEL_W-1:0]),
    .bus_idle    (idle_count >= 3'(mac_queue_pkg::IDLE_CLOCKS)),
    .resource_ok (rx_descriptor_active),
    .extra_event (rx_end_of_frame),
    .bus_request (rx_data_request)
  );

  fifo_request_scheduler #(
    .LEVEL_W (FIFO_LEVEL_W)
  ) u_tx_sched (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .fill_words  (tx_fifo_empty_words),
    .soft_level  (tx_thr_soft[FIFO_LEVEL_W-1:0]),
    .hard_level  (tx_thr_hard[FIFO_LEVEL_W-1:0]),
    .bus_idle    (idle_count >= 3'(mac_queue_pkg::IDLE_CLOCKS)),
    .resource_ok (tx_descriptor_active),
    .extra_event (1'b0),
    .bus_request (tx_data_request)
  );

endmodule

// [sim/mac_queue_props.sv]
// Checker: port-level properties of the queue and threshold block
`timescale 1ns/1ps
module mac_queue_props #(
  parameter int FIFO_LEVEL_W = 14
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        descriptors_read,
  input wire logic [7:0]  descriptors_read_count,
  input wire logic        status_written,
  input wire logic        rx_descriptor_active,
  input wire logic        rx_end_of_frame,
  input wire logic        tx_descriptor_active,
  input wire logic        tx_descriptor_request,
  input wire logic        rx_data_request,
  input wire logic        tx_data_request,
  input wire logic [31:0] status_write_address
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Shadow of the valid descriptor count
  // ----------------------------------------
  logic [15:0] model_cnt;
  logic [15:0] next_model_cnt;
  logic        aw_hs;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  always_comb begin
    next_model_cnt = model_cnt;
    if (aw_hs && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
        && s_axi_awaddr == mac_queue_pkg::ADDR_TX_DESCRIPTOR_ENQUEUE) begin
      next_model_cnt = next_model_cnt + 16'(s_axi_wdata[7:0]);
    end
    if (descriptors_read) begin
      next_model_cnt = next_model_cnt - 16'(descriptors_read_count);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      model_cnt <= 16'h0000;
    end else begin
      model_cnt <= next_model_cnt;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  desc_zero_a: assert property ((model_cnt == 16'h0000) [*3] |-> !tx_descriptor_request)
    else $error("descriptor request with zero count");
  desc_count_a: assert property ((model_cnt != 16'h0000) [*3] |-> tx_descriptor_request)
    else $error("descriptor request missing with nonzero count");
  rx_hold_a: assert property (!rx_descriptor_active |=> !rx_data_request)
    else $error("receive request without active descriptor");
  tx_hold_a: assert property (!tx_descriptor_active |=> !tx_data_request)
    else $error("transmit request without active descriptor");
  rx_eof_a: assert property (rx_descriptor_active && rx_end_of_frame |=> rx_data_request)
    else $error("end of frame did not request");
  ptr_still_a: assert property ((!status_written && !aw_hs) [*2] |=> $stable(status_write_address))
    else $error("status pointer moved without cause");
  wr_resp_a: assert property (aw_hs && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule

// [sim/mac_side_model.sv]
// Partner: MAC-side model of descriptor reader, status writer, FIFO levels and bus activity
`timescale 1ns/1ps
module mac_side_model #(
  parameter int FIFO_LEVEL_W = 14
) (
  input  wire logic              aclk,
  output logic                   descriptors_read,
  output logic [7:0]             descriptors_read_count,
  output logic                   status_written,
  output logic [7:0]             status_bytes_written,
  output logic                   ahb_transfer,
  output logic [FIFO_LEVEL_W-1:0] rx_fifo_words,
  output logic                   rx_descriptor_active,
  output logic                   rx_end_of_frame,
  output logic [FIFO_LEVEL_W-1:0] tx_fifo_empty_words,
  output logic                   tx_descriptor_active
);
  initial begin
    {descriptors_read, status_written, ahb_transfer, rx_end_of_frame} = 4'h0;
    {rx_descriptor_active, tx_descriptor_active} = 2'h0;
    {descriptors_read_count, status_bytes_written} = 16'hA5A5;
    rx_fifo_words = '0;
    tx_fifo_empty_words = '0;
  end
  // Count lines carry junk between pulses so stale values are never trusted
  task automatic read_desc(input logic [7:0] n);
    @(posedge aclk);
    descriptors_read <= 1'b1;
    descriptors_read_count <= n;
    @(posedge aclk);
    descriptors_read <= 1'b0;
    descriptors_read_count <= ~n;
  endtask
  task automatic write_status(input logic [7:0] b);
    @(posedge aclk);
    status_written <= 1'b1;
    status_bytes_written <= b;
    @(posedge aclk);
    status_written <= 1'b0;
    status_bytes_written <= ~b;
  endtask
  task automatic end_frame();
    @(posedge aclk);
    rx_end_of_frame <= 1'b1;
    @(posedge aclk);
    rx_end_of_frame <= 1'b0;
  endtask
  task automatic set_side(input bit tx, input logic [FIFO_LEVEL_W-1:0] lv, input logic act,
                          input logic busy);
    @(posedge aclk);
    ahb_transfer <= busy;
    if (tx) begin
      tx_fifo_empty_words <= lv;
      tx_descriptor_active <= act;
    end else begin
      rx_fifo_words <= lv;
      rx_descriptor_active <= act;
    end
  endtask
endmodule

// [sim/mac_queue_and_fifo_thresholds_tb.sv]
// Testbench: registers, descriptor count, status queue and FIFO request scenarios
`timescale 1ns/1ps
module mac_queue_and_fifo_thresholds_tb;
  localparam int LW = 14;
  localparam logic [11:0] A_ENQ = mac_queue_pkg::ADDR_TX_DESCRIPTOR_ENQUEUE;
  localparam logic [11:0] A_BA = mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_ADDRESS;
  localparam logic [11:0] A_BL = mac_queue_pkg::ADDR_TX_STATUS_QUEUE_BASE_LENGTH;
  localparam logic [11:0] A_CL = mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_LENGTH;
  localparam logic [11:0] A_CA = mac_queue_pkg::ADDR_TX_STATUS_QUEUE_CURRENT_ADDRESS;
  localparam logic [11:0] A_RT = mac_queue_pkg::ADDR_RX_DATA_FIFO_THRESHOLD;
  localparam logic [11:0] A_TT = mac_queue_pkg::ADDR_TX_DATA_FIFO_THRESHOLD;
  localparam logic [11:0] REGS [7] = '{A_ENQ, A_BA, A_BL, A_CL, A_CA, A_RT, A_TT};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, status_write_address, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic descriptors_read, status_written, ahb_transfer, rx_descriptor_active, rx_end_of_frame;
  logic tx_descriptor_active, tx_descriptor_request, rx_data_request, tx_data_request;
  logic [7:0]  descriptors_read_count, status_bytes_written;
  logic [LW-1:0] rx_fifo_words, tx_fifo_empty_words;
  int n_errors, cmp_count;
  mac_queue_and_fifo_thresholds #(.FIFO_LEVEL_W(LW)) mac_queue_and_fifo_thresholds_inst (.*);
  mac_side_model #(.FIFO_LEVEL_W(LW)) mac_side_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(rd, exp);
  endtask
  // Sets one FIFO side, waits n cycles, then samples that side's request
  task automatic lvl(input bit tx, input logic [LW-1:0] v, input logic act, input logic busy,
                     input int n, input logic exp);
    mac_side_model_inst.set_side(tx, v, act, busy);
    repeat (n) @(posedge aclk);
    check(tx ? tx_data_request : rx_data_request, exp);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (REGS[i]) rdc(REGS[i], 32'h0000_0000);
    rdc(12'h004, 32'h0000_0000);
    check(rs, mac_queue_pkg::RESP_SLVERR);
    wr(12'h004, 32'h0000_0001);
    check(rs, mac_queue_pkg::RESP_SLVERR);
    $display("test reset_and_map done");
    wr(A_ENQ, 32'h0000_0007);
    wr(A_ENQ, 32'h0000_0003);
    rdc(A_ENQ, 32'h000A_0000);
    wr(A_ENQ, 32'hFFFF_0000);
    rdc(A_ENQ, 32'h000A_0000);
    s_axi_wstrb <= 4'hE;
    wr(A_ENQ, 32'h0000_0005);
    rdc(A_ENQ, 32'h000A_0000);
    s_axi_wstrb <= 4'hF;
    mac_side_model_inst.read_desc(8'h02);
    rdc(A_ENQ, 32'h0008_0000);
    check(tx_descriptor_request, 1'b1);
    mac_side_model_inst.read_desc(8'h08);
    rdc(A_ENQ, 32'h0000_0000);
    check(tx_descriptor_request, 1'b0);
    $display("test descriptor_count done");
    wr(A_BA, 32'h2000_0000);
    wr(A_BL, 32'h0000_0010);
    wr(A_CA, 32'h2000_0000);
    wr(A_CL, 32'h0000_0010);
    mac_side_model_inst.write_status(8'h08);
    rdc(A_CA, 32'h2000_0008);
    rdc(A_CL, 32'h0000_0008);
    check(status_write_address, 32'h2000_0008);
    mac_side_model_inst.write_status(8'h08);
    rdc(A_CA, 32'h2000_0000);
    rdc(A_CL, 32'h0000_0010);
    check(status_write_address, 32'h2000_0000);
    $display("test status_queue done");
    wr(A_RT, 32'hFFFF_FFFF);
    rdc(A_RT, 32'h3FFC_3FFC);
    for (int s = 0; s < 2; s++) begin
      wr(s ? A_TT : A_RT, 32'h0080_0040);
      lvl(s[0], 14'h0041, 1'b1, 1'b1, 8, 1'b0);
      lvl(s[0], 14'h0041, 1'b1, 1'b0, 8, 1'b1);
      lvl(s[0], 14'h0080, 1'b1, 1'b1, 8, 1'b0);
      lvl(s[0], 14'h0081, 1'b1, 1'b1, 2, 1'b1);
      lvl(s[0], 14'h0081, 1'b0, 1'b1, 2, 1'b0);
    end
    mac_side_model_inst.set_side(1'b0, 14'h0000, 1'b1, 1'b1);
    mac_side_model_inst.end_frame();
    @(posedge aclk);
    check(rx_data_request, 1'b1);
    $display("test fifo_requests done");
    close_out();
  end
endmodule
bind mac_queue_and_fifo_thresholds mac_queue_props #(.FIFO_LEVEL_W(FIFO_LEVEL_W))
  props_inst (.*);
